// ===== shared/sfsc_defines.svh
`ifndef SFSC_DEFINES_SVH
`define SFSC_DEFINES_SVH

`define SFSC_ADDR_W          4
`define SFSC_OFS_CONTROL     4'h0
`define SFSC_OFS_BAUD        4'h4
`define SFSC_OFS_DATA        4'h8
`define SFSC_OFS_STATUS      4'hC

`define SFSC_BIT_FRM_EN      31
`define SFSC_BIT_SYNC_DIR    30
`define SFSC_BIT_SYNC_POL    29
`define SFSC_BIT_MSS_EN      28
`define SFSC_BIT_SYNC_WIDTH  27
`define SFSC_BIT_CNT_HI      26
`define SFSC_BIT_CNT_LO      24
`define SFSC_BIT_CLK_SEL     23
`define SFSC_BIT_ON          15
`define SFSC_BIT_CKE         8
`define SFSC_BIT_CKP         6
`define SFSC_BIT_MASTER      5
`define SFSC_BIT_AUDIO       4

`define SFSC_CONTROL_RESET   32'h0000_0000
`define SFSC_CONTROL_MASK    32'hFF80_8170
`define SFSC_BAUD_RESET      8'h01
`define SFSC_CHAR_BITS       8
`define SFSC_CNT_W           6

`define SFSC_CLK_MHZ         125
`define SFSC_CLK_PERIOD_NS   8

`endif

// ===== shared/sfsc_pkg.sv
package sfsc_pkg;

	typedef enum logic [2:0] {
		SFSC_IDLE  = 3'b000,
		SFSC_SYNC  = 3'b001,
		SFSC_SHIFT = 3'b011,
		SFSC_DONE  = 3'b010
	} sfsc_state_t;

	typedef logic [7:0] sfsc_char_t;

endpackage

// ===== verilog/sfsc_buffer.sv
`timescale 1ns/1ns
`default_nettype none

// Two-entry skid buffer; full rate with registered ready
module sfsc_buffer (
	// Clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_sys_rst,
	// Fill side
	input  wire logic       i_in_valid,
	input  wire logic [7:0] i_in_data,
	output logic            o_in_ready,
	// Drain side
	output logic            o_out_valid,
	output logic [7:0]      o_out_data,
	input  wire logic       i_out_ready
);

	typedef struct packed {
		logic [7:0] slot0;
		logic [7:0] slot1;
		logic [1:0] count;
	} sfsc_buf_state_t;

	sfsc_buf_state_t state_reg;
	sfsc_buf_state_t state_next;

	logic push;
	logic pop;

	assign o_in_ready  = (state_reg.count != 2'h2);
	assign o_out_valid = (state_reg.count != 2'h0);
	assign o_out_data  = state_reg.slot0;
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_comb begin
		state_next = state_reg;
		if (pop) begin
			state_next.slot0 = state_reg.slot1;
		end
		if (push) begin
			if (state_reg.count == 2'h0 || (state_reg.count == 2'h1 && pop)) begin
				state_next.slot0 = i_in_data;
			end else begin
				state_next.slot1 = i_in_data;
			end
		end
		case ({push, pop})
			2'b10: state_next.count = state_reg.count + 2'h1;
			2'b01: state_next.count = state_reg.count - 2'h1;
			default: state_next.count = state_reg.count;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule

`default_nettype wire

// ===== verilog/sfsc_core.sv
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "sfsc_defines.svh"

module sfsc_core (
	// Clock and reset
	input  wire logic                       i_clock,
	input  wire logic                       i_sys_rst,
	// Register port
	input  wire logic [`SFSC_ADDR_W-1:0]    i_addr,
	input  wire logic [31:0]                i_wdata,
	input  wire logic                       i_wr,
	input  wire logic                       i_rd,
	output logic [31:0]                     o_rdata,
	// Baud sources
	input  wire logic                       i_ref_tick,
	// Transmit data stream
	input  wire logic                       i_tx_valid,
	input  wire logic [7:0]                 i_tx_data,
	output logic                            o_tx_ready,
	// Serial pins
	output logic                            o_sck,
	output logic                            o_sdo,
	input  wire logic                       i_sdi,
	input  wire logic                       i_sel,
	output logic                            o_sel,
	output logic                            o_sel_oe,
	// Status
	output logic                            o_busy
);

	typedef struct packed {
		logic [31:0]             control;
		logic [7:0]              baud_div;
		logic [7:0]              baud_cnt;
		sfsc_pkg::sfsc_state_t   fsm;
		logic [7:0]              shift;
		logic [7:0]              rx_shift;
		logic [7:0]              rx_data;
		logic                    rx_full;
		logic [3:0]              bit_cnt;
		logic                    phase;
		logic [`SFSC_CNT_W-1:0]  char_cnt;
		logic                    sync_act;
		logic                    sel_act;
		logic                    sck;
		logic                    sdo;
		logic                    sel_prev;
		logic [31:0]             rdata;
	} sfsc_core_state_t;

	sfsc_core_state_t s_reg;
	sfsc_core_state_t s_next;

	logic                   buf_valid;
	logic [7:0]             buf_data;
	logic                   buf_ready;
	logic                   frm_en;
	logic                   sync_out;
	logic                   pol;
	logic                   ckp_eff;
	logic                   master;
	logic                   baud_tick;
	logic                   ext_sync;
	logic [`SFSC_CNT_W-1:0] period;

	// Characters between sync pulses; reserved codes fall back to one
	function automatic logic [`SFSC_CNT_W-1:0] sync_period(input logic [2:0] code);
		case (code)
			3'b101: sync_period = 6'd32;
			3'b100: sync_period = 6'd16;
			3'b011: sync_period = 6'd8;
			3'b010: sync_period = 6'd4;
			3'b001: sync_period = 6'd2;
			default: sync_period = 6'd1;
		endcase
	endfunction

	sfsc_buffer u_buffer (
		.i_clock     (i_clock),
		.i_sys_rst   (i_sys_rst),
		.i_in_valid  (i_tx_valid),
		.i_in_data   (i_tx_data),
		.o_in_ready  (o_tx_ready),
		.o_out_valid (buf_valid),
		.o_out_data  (buf_data),
		.i_out_ready (buf_ready)
	);

	assign frm_en   = s_reg.control[`SFSC_BIT_FRM_EN];
	assign sync_out = ~s_reg.control[`SFSC_BIT_SYNC_DIR];
	assign pol      = s_reg.control[`SFSC_BIT_SYNC_POL];
	assign master   = s_reg.control[`SFSC_BIT_MASTER];
	assign ckp_eff  = s_reg.control[`SFSC_BIT_CKP] | s_reg.control[`SFSC_BIT_AUDIO];
	// Reference ticks are expected pre-synchronised as one-cycle pulses
	assign baud_tick = s_reg.control[`SFSC_BIT_CLK_SEL] ? i_ref_tick : 1'b1;
	assign period   = frm_en ? sync_period(s_reg.control[`SFSC_BIT_CNT_HI:`SFSC_BIT_CNT_LO])
	                         : 6'd1;
	// Partner-driven sync start, seen as an edge to its active level
	assign ext_sync = frm_en && !sync_out && (i_sel == pol) && (s_reg.sel_prev != pol);
	assign buf_ready = s_reg.control[`SFSC_BIT_ON] && (s_reg.fsm == sfsc_pkg::SFSC_IDLE)
	                   && (frm_en && !sync_out ? ext_sync : master);

	always_comb begin
		s_next          = s_reg;
		s_next.sel_prev = i_sel;
		s_next.rdata    = 32'h0000_0000;
		if (i_wr) begin
			case (i_addr)
				`SFSC_OFS_CONTROL: s_next.control = i_wdata & `SFSC_CONTROL_MASK;
				`SFSC_OFS_BAUD:    s_next.baud_div = i_wdata[7:0];
				default: ;
			endcase
		end
		if (i_rd) begin
			case (i_addr)
				`SFSC_OFS_CONTROL: s_next.rdata = s_reg.control;
				`SFSC_OFS_BAUD:    s_next.rdata = {24'h000000, s_reg.baud_div};
				`SFSC_OFS_DATA: begin
					s_next.rdata   = {24'h000000, s_reg.rx_data};
					s_next.rx_full = 1'b0;
				end
				`SFSC_OFS_STATUS:  s_next.rdata = {29'h0, s_reg.rx_full, buf_valid,
				                                   s_reg.fsm != sfsc_pkg::SFSC_IDLE};
				default:           s_next.rdata = 32'h0000_0000;
			endcase
		end
		case (s_reg.fsm)
			sfsc_pkg::SFSC_IDLE: begin
				s_next.sck      = ckp_eff;
				s_next.sel_act  = 1'b0;
				s_next.sync_act = 1'b0;
				if (buf_ready && buf_valid) begin
					s_next.shift    = buf_data;
					s_next.bit_cnt  = 4'h0;
					s_next.phase    = 1'b0;
					s_next.baud_cnt = 8'h00;
					s_next.sel_act  = !frm_en;
					if (frm_en && sync_out && s_reg.char_cnt == 6'd0) begin
						s_next.sync_act = 1'b1;
					end
					s_next.fsm = sfsc_pkg::SFSC_SHIFT;
				end
			end
			sfsc_pkg::SFSC_SHIFT: begin
				if (baud_tick) begin
					if (s_reg.baud_cnt >= s_reg.baud_div) begin
						s_next.baud_cnt = 8'h00;
						s_next.phase    = ~s_reg.phase;
						s_next.sck      = ~s_reg.sck;
						if (!s_reg.phase) begin
							s_next.sdo      = s_reg.shift[7];
							s_next.rx_shift = {s_reg.rx_shift[6:0], i_sdi};
						end else begin
							s_next.shift   = {s_reg.shift[6:0], 1'b0};
							s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
							// One clock wide sync ends after first bit
							if (!s_reg.control[`SFSC_BIT_SYNC_WIDTH]) begin
								s_next.sync_act = 1'b0;
							end
							if (s_reg.bit_cnt == 4'(`SFSC_CHAR_BITS - 1)) begin
								// Character-wide sync ends with the last bit, not one cycle late
								s_next.sync_act = 1'b0;
								s_next.fsm      = sfsc_pkg::SFSC_DONE;
							end
						end
					end else begin
						s_next.baud_cnt = s_reg.baud_cnt + 8'h01;
					end
				end
			end
			sfsc_pkg::SFSC_DONE: begin
				s_next.sync_act = 1'b0;
				s_next.sel_act  = 1'b0;
				s_next.rx_data  = s_reg.rx_shift;
				s_next.rx_full  = 1'b1;
				s_next.char_cnt = (s_reg.char_cnt + 6'd1 >= period) ? 6'd0
				                  : s_reg.char_cnt + 6'd1;
				s_next.fsm      = sfsc_pkg::SFSC_IDLE;
			end
			default: s_next.fsm = sfsc_pkg::SFSC_IDLE;
		endcase
		if (!s_reg.control[`SFSC_BIT_ON] || !frm_en) begin
			if (!frm_en) begin
				s_next.char_cnt = 6'd0;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			s_reg          <= '0;
			s_reg.control  <= `SFSC_CONTROL_RESET;
			s_reg.baud_div <= `SFSC_BAUD_RESET;
			s_reg.fsm      <= sfsc_pkg::SFSC_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_rdata = s_reg.rdata;
	assign o_sck   = s_reg.sck;
	assign o_sdo   = s_reg.sdo;
	assign o_busy  = (s_reg.fsm != sfsc_pkg::SFSC_IDLE);
	// Select pin: sync output in framed mode, auto select in master mode
	assign o_sel    = frm_en ? (s_reg.sync_act ? pol : ~pol)
	                         : (s_reg.sel_act ? pol : ~pol);
	assign o_sel_oe = s_reg.control[`SFSC_BIT_ON] &&
	                  (frm_en ? sync_out
	                          : (master && s_reg.control[`SFSC_BIT_MSS_EN]));

endmodule

`default_nettype wire

// ===== test/sfsc_core_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "sfsc_defines.svh"
module sfsc_core_monitor (
	// Clock and reset
	input wire logic        i_clock,
	input wire logic        i_sys_rst,
	// Register port
	input wire logic [3:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	// Pins
	input wire logic        o_sck,
	input wire logic        o_sel,
	input wire logic        o_sel_oe,
	input wire logic        o_busy
);
	logic [31:0] ctl_reg;
	always_ff @(posedge i_clock) begin
		if (i_sys_rst)
			ctl_reg <= `SFSC_CONTROL_RESET;
		else if (i_wr && i_addr == `SFSC_OFS_CONTROL)
			ctl_reg <= i_wdata & `SFSC_CONTROL_MASK;
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data outside slot");
	ctl_read_a: assert property (i_rd && i_addr == 4'h0 |=> o_rdata == $past(ctl_reg))
		else $error("control read mismatch");
	hole_read_a: assert property (i_rd && i_addr[1:0] != 2'h0 |=> o_rdata == 32'h0)
		else $error("unmapped read not zero");
	idle_clock_a: assert property (!o_busy && !$past(o_busy) && $stable(ctl_reg)
		|-> o_sck == (ctl_reg[6] | ctl_reg[4])) else $error("clock idle level");
	no_drive_a: assert property (!ctl_reg[31] && !ctl_reg[28] |-> !o_sel_oe)
		else $error("select driven");
	auto_sel_a: assert property (ctl_reg[28] && ctl_reg[5] && ctl_reg[15] && !ctl_reg[31]
		&& o_busy |-> o_sel_oe && o_sel == ctl_reg[29]) else $error("auto select wrong");
	sync_in_a: assert property (ctl_reg[31] && ctl_reg[30] |-> !o_sel_oe)
		else $error("sync input driven");
	sync_idle_a: assert property (ctl_reg[31] && !ctl_reg[30] && ctl_reg[15] && !o_busy
		&& !$past(o_busy) && $stable(ctl_reg) |-> o_sel_oe && o_sel != ctl_reg[29])
		else $error("sync idle");
endmodule
bind sfsc_core sfsc_core_monitor i_sfsc_core_monitor (.i_clock, .i_sys_rst, .i_addr, .i_wdata,
	.i_wr, .i_rd, .o_rdata, .o_sck, .o_sel, .o_sel_oe, .o_busy);
`default_nettype wire

// ===== test/sfsc_peer.sv
`timescale 1ns/1ns
`default_nettype none
module sfsc_peer (
	// Serial link
	input wire logic i_clock,
	input wire logic i_sck,
	input wire logic i_sdo,
	output logic     o_sdi,
	// Sync drive
	input wire logic i_go,
	input wire logic i_pol,
	output logic     o_sync
);
	logic sck_reg;
	initial o_sdi = 1'b0;
	initial sck_reg = 1'b0;
	// Line toggles unless loaded, so a stale bit never looks valid
	always @(posedge i_clock) begin
		sck_reg <= i_sck;
		o_sdi <= (i_sck != sck_reg) ? i_sdo : !o_sdi;
	end
	assign o_sync = i_go ~^ i_pol;
endmodule
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "sfsc_defines.svh"
module testbench;
	logic        i_clock, i_sys_rst, i_wr, i_rd, i_ref_tick, i_tx_valid, act_d;
	logic        o_tx_ready, o_sck, o_sdo, sdi, sync, sel_line, o_sel, o_sel_oe, o_busy;
	logic        go, pol, tick_en, sck_d;
	logic [3:0]  i_addr;
	logic [7:0]  i_tx_data, tx_cap;
	logic [31:0] i_wdata, o_rdata;
	int          n_fail, checks_done, pulses, p0, k, run, width;
	localparam logic [31:0] C_ON = 32'h0000_8000, C_MST = 32'h0000_0020, C_AUD = 32'h0000_0010;
	localparam logic [31:0] C_FRM = 32'h8000_0000, C_DIR = 32'h4000_0000, C_POL = 32'h2000_0000;
	localparam logic [31:0] C_ASEL = 32'h1000_0000, C_WID = 32'h0800_0000, C_CSEL = 32'h0080_0000;
	assign sel_line = o_sel_oe ? o_sel : sync;
	sfsc_core i_sfsc_core (.i_clock, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_ref_tick, .i_tx_valid, .i_tx_data, .o_tx_ready, .o_sck, .o_sdo, .i_sdi(sdi),
		.i_sel(sel_line), .o_sel, .o_sel_oe, .o_busy);
	sfsc_peer i_sfsc_peer (.i_clock, .i_sck(o_sck), .i_sdo(o_sdo), .o_sdi(sdi), .i_go(go),
		.i_pol(pol), .o_sync(sync));
	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = !i_clock;
	end
	always @(posedge i_clock) begin
		i_ref_tick <= tick_en && !i_ref_tick;
		act_d <= sel_line ~^ pol;
		if ((sel_line ~^ pol) && !act_d) pulses++;
		run <= (sel_line ~^ pol) ? run + 1 : 0;
		if (!(sel_line ~^ pol) && act_d) width <= run;
		// Data is stable on the rising clock in either idle polarity
		sck_d <= o_sck;
		if (o_sck && !sck_d) tx_cap <= {tx_cap[6:0], o_sdo};
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
		@(posedge i_clock);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		@(negedge i_clock);
		chk(o_rdata, e);
		@(posedge i_clock);
	endtask
	// Valid stays up between words; buffer refusal stalls us
	task automatic send(input logic [7:0] d);
		i_tx_valid <= 1'b1;
		i_tx_data <= d;
		@(negedge i_clock);
		while (!o_tx_ready) @(negedge i_clock);
		@(posedge i_clock);
	endtask
	task automatic idle;
		i_tx_valid <= 1'b0;
		k = 0;
		while (k < 40) begin
			@(negedge i_clock);
			k = o_busy ? 0 : k + 1;
		end
		@(posedge i_clock);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#400000;
		n_fail++;
		give_verdict;
	end
	initial begin
		{i_sys_rst, i_wr, i_rd, i_tx_valid, i_ref_tick, act_d, go, pol, tick_en} = 9'h100;
		{i_addr, i_tx_data, i_wdata} = 44'h0;
		{n_fail, checks_done, pulses, run, width} = '0;
		repeat (16) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		@(posedge i_clock);
		rd(`SFSC_OFS_CONTROL, `SFSC_CONTROL_RESET);
		rd(`SFSC_OFS_BAUD, 32'h0000_0001);
		rd(4'h2, 32'h0);
		wr(`SFSC_OFS_CONTROL, 32'hF8FF_FFFF);
		rd(`SFSC_OFS_CONTROL, 32'hF880_8170);
		wr(`SFSC_OFS_BAUD, 32'h0);
		$display("registers done");
		for (int p = 0; p < 4; p++) begin
			pol = p[0];
			wr(4'h0, C_ON | C_MST | 32'h0500_0000 | (p[0] ? C_POL : 0) | (p[1] ? C_ASEL : 0));
			p0 = pulses;
			send(8'hA5);
			send(8'h3C);
			send(8'hF0);
			idle;
			chk(32'(pulses - p0), p[1] ? 32'h3 : 32'h0);
			chk({24'h0, tx_cap}, 32'h0000_00F0);
		end
		$display("auto select done");
		wr(4'h0, C_ON | C_MST | C_AUD);
		send(8'h99);
		idle;
		chk({31'h0, o_sck}, 32'h1);
		chk({24'h0, tx_cap}, 32'h0000_0099);
		rd(`SFSC_OFS_STATUS, 32'h0000_0004);
		$display("audio done");
		for (int c = 1; c < 6; c++) begin
			pol = c[0];
			wr(4'h0, C_ON | C_MST | C_FRM | (c[0] ? C_POL | C_WID : 0) | (32'(c) << 24));
			idle;
			p0 = pulses;
			repeat (2 << c) send(8'h5A);
			idle;
			chk(32'(pulses - p0), 32'h2);
			chk(32'(width), c[0] ? 32'(2 * `SFSC_CHAR_BITS) : 32'h2);
		end
		$display("framed output done");
		pol = 1'b1;
		wr(4'h0, C_ON | C_FRM | C_DIR | C_POL);
		send(8'h81);
		i_tx_valid <= 1'b0;
		repeat (30) @(negedge i_clock);
		chk({31'h0, o_busy}, 32'h0);
		@(posedge i_clock);
		go <= 1'b1;
		repeat (2) @(posedge i_clock);
		go <= 1'b0;
		repeat (4) @(negedge i_clock);
		chk({31'h0, o_busy}, 32'h1);
		idle;
		$display("framed input done");
		wr(4'h0, C_ON | C_MST | C_CSEL);
		send(8'h66);
		i_tx_valid <= 1'b0;
		repeat (60) @(negedge i_clock);
		chk({31'h0, o_busy}, 32'h1);
		@(posedge i_clock);
		tick_en <= 1'b1;
		idle;
		chk({24'h0, tx_cap}, 32'h0000_0066);
		$display("baud source done");
		give_verdict;
	end
endmodule
`default_nettype wire
